/* File: inc/sprme_consts.svh */
`ifndef SPRME_CONSTS_SVH
`define SPRME_CONSTS_SVH
`define SPRME_MOD_FORM_BIT 7
`define SPRME_MOD_RANGE_BIT 3
`define SPRME_MOD_ADDR_LSB 4
`define SPRME_MOD_CLASS_MSB 2
`define SPRME_TS_MM2_BIT 6
`define SPRME_SLV_INT_REQ 4'h8
`define SPRME_NO_CLASS 3'h0
`define SPRME_RST_WIDTH_DBL 1'b0
`define SPRME_RST_STREAM 1'b0
`define SPRME_SYNC_STAGES 3
`endif

/* File: inc/sprme_pkg.sv */
package sprme_pkg;
  typedef enum logic [2:0] {
    SPRME_IDLE, SPRME_REQUEST, SPRME_REQUACK, SPRME_RESETSEL1, SPRME_RESETSEL2, SPRME_MAINT
  } sprme_bus_state_t;
  typedef struct packed {
    logic       vendor;
    logic       busy;
    logic       ready;
    logic       prioHold;
    logic       prioSel;
    logic [2:0] classPend;
  } sprme_status_t;
  typedef struct packed {
    logic canStream;
    logic canInterlock;
    logic canDouble;
    logic canSingle;
    logic hasMm2;
  } sprme_caps_t;
endpackage : sprme_pkg

/* File: hw/sprme_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sprme_consts.svh"
module sprme_slave
  import sprme_pkg::*;
#(
  parameter logic [2:0] SLAVE_ADDR = 3'h0
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire sprme_bus_state_t busState,
  input  wire logic [7:0]       busAIn,
  input  wire sprme_status_t    slaveStatus,
  input  wire logic             powerOn,
  input  wire logic [15:1]      facilityInt,
  input  wire sprme_caps_t      caps,
  input  wire logic             setModeStb,
  input  wire logic             setDouble,
  input  wire logic             setStream,
  input  wire logic             masterHasMm2,
  input  wire logic [2:0]       maintTri,
  input  wire logic             funcDriveEn,
  input  wire logic [7:0]       funcBusBOut,
  input  wire logic             funcDominantReq,
  input  wire logic             maintDriveRel,
  output logic [7:0]            busBOut,
  output logic [7:0]            busBOeN,
  output logic                  parityOeN,
  output logic                  divertToMaint,
  output logic                  mm2Active,
  output logic                  dominantGrant,
  output logic                  selResetStb,
  output logic [3:0]            selResetKind,
  output logic                  curDouble,
  output logic                  curStream
);
  logic [2:0] voteS1_q, voteS2_q, voteS3_q;
  logic       maint_q;
  logic [7:0] resetOctet_q;
  logic [7:0] outData_q, outOe_q;
  logic       outPar_q;
  logic       curDouble_q, curStream_q;
  logic       rsSeen_q;
  logic       maintRaw, maintStable;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      voteS1_q <= 3'h0;
      voteS2_q <= 3'h0;
      voteS3_q <= 3'h0;
    end else begin
      voteS1_q <= maintTri;
      voteS2_q <= voteS1_q;
      voteS3_q <= voteS2_q;
    end
  end
  // majority of three static levels
  assign maintRaw = (voteS2_q[0] & voteS2_q[1]) | (voteS2_q[0] & voteS2_q[2])
                  | (voteS2_q[1] & voteS2_q[2]);
  wire maintPrev = (voteS3_q[0] & voteS3_q[1]) | (voteS3_q[0] & voteS3_q[2])
                 | (voteS3_q[1] & voteS3_q[2]);
  assign maintStable = (maintRaw == maintPrev);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) maint_q <= 1'b0;
    else if (maintStable) maint_q <= maintRaw | (busState == SPRME_MAINT);
  end
  // request decode
  wire       reqForm    = busAIn[`SPRME_MOD_FORM_BIT];
  wire [2:0] reqAddr    = busAIn[6:4];
  wire       addrHit    = (reqAddr == SLAVE_ADDR);
  wire [2:0] reqClass   = busAIn[`SPRME_MOD_CLASS_MSB:0];
  wire       pollHit    = (busAIn[6] & slaveStatus.busy) | (busAIn[5] & slaveStatus.ready)
                        | busAIn[4] | (busAIn[3] & powerOn)
                        | |(reqClass & slaveStatus.classPend);
  wire       slvIntReq  = reqForm & addrHit & (busAIn[3:0] == `SPRME_SLV_INT_REQ);
  wire       tsReq      = reqForm & addrHit & (busAIn[3:0] == 4'h0);
  wire       facReq     = reqForm & addrHit & (reqClass != `SPRME_NO_CLASS);
  wire [15:1] facMatch;
  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++) begin : g_fac
      assign facMatch[gi] = facilityInt[gi] & |(reqClass & 3'h7);
    end
  endgenerate
  wire [7:0] facOctet  = busAIn[`SPRME_MOD_RANGE_BIT] ? {facMatch[15:9], 1'b0}
                                                      : {facMatch[7:1], 1'b0};
  wire [7:0] tsOctet   = {1'b0, caps.hasMm2 & masterHasMm2, curDouble_q, curStream_q,
                          caps.canStream, caps.canInterlock, caps.canDouble,
                          caps.canSingle};
  wire [7:0] siOctet   = {slaveStatus.vendor, slaveStatus.busy, slaveStatus.ready,
                          slaveStatus.prioHold, slaveStatus.prioSel,
                          slaveStatus.classPend};
  wire [7:0] ownBit    = 8'h01 << SLAVE_ADDR;
  wire       inMaint   = maint_q;
  wire       pollOn    = !inMaint && busState == SPRME_REQUEST && !reqForm && pollHit;
  wire       ackOn     = !inMaint && busState == SPRME_REQUACK && reqForm && addrHit;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) resetOctet_q <= 8'h00;
    else if (busState == SPRME_REQUEST) resetOctet_q <= busAIn;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rsSeen_q <= 1'b0;
    else rsSeen_q <= (busState == SPRME_RESETSEL1);
  end
  wire rsAddrHit = resetOctet_q[6:4] == SLAVE_ADDR;
  assign selResetStb  = (busState == SPRME_RESETSEL1) && !rsSeen_q && rsAddrHit;
  assign selResetKind = resetOctet_q[3:0];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      curDouble_q <= `SPRME_RST_WIDTH_DBL;
      curStream_q <= `SPRME_RST_STREAM;
    end else if (setModeStb) begin
      if ((setDouble & caps.canDouble) | (!setDouble & caps.canSingle))
        curDouble_q <= setDouble;
      if ((setStream & caps.canStream) | (!setStream & caps.canInterlock))
        curStream_q <= setStream;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      outData_q <= 8'h00;
      outOe_q   <= 8'h00;
      outPar_q  <= 1'b0;
    end else if (pollOn) begin
      outData_q <= ownBit;
      outOe_q   <= ownBit;
      outPar_q  <= 1'b0;
    end else if (ackOn && facReq) begin
      outData_q <= facOctet;
      outOe_q   <= facOctet;
      outPar_q  <= 1'b0;
    end else if (ackOn && (slvIntReq || tsReq)) begin
      outData_q <= slvIntReq ? siOctet : tsOctet;
      outOe_q   <= 8'hFF;
      outPar_q  <= 1'b1;
    end else begin
      outData_q <= 8'h00;
      outOe_q   <= 8'h00;
      outPar_q  <= 1'b0;
    end
  end
  wire relAll = inMaint;
  wire useFunc = !inMaint && funcDriveEn && !outOe_q[0] && outOe_q == 8'h00;
  assign busBOut   = useFunc ? funcBusBOut : outData_q;
  assign busBOeN   = relAll ? 8'hFF : (useFunc ? 8'h00 : ~outOe_q);
  assign parityOeN = relAll ? 1'b1 : ~(outPar_q | useFunc);
  assign divertToMaint = inMaint & ~maintDriveRel;
  assign mm2Active     = inMaint & caps.hasMm2 & masterHasMm2;
  assign dominantGrant = funcDominantReq & ~inMaint;
  assign curDouble = curDouble_q;
  assign curStream = curStream_q;

  poll_own_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    pollOn && !inMaint |=> (busBOeN | ownBit) == 8'hFF || useFunc)
    else $error("poll drove foreign bit");
  poll_parity_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(pollOn) && !inMaint && !useFunc |-> parityOeN)
    else $error("parity driven on address octet");
  maint_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
    maint_q |-> busBOeN == 8'hFF && parityOeN)
    else $error("drivers not released in maint");
  dominant_block_a: assert property (@(posedge core_clk) disable iff (!nrst)
    maint_q |-> !dominantGrant)
    else $error("dominant grant in maint");
  reset_capture_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busState == SPRME_REQUEST |=> resetOctet_q == $past(busAIn))
    else $error("reset octet not captured");
  no_reset_ans_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(busState) == SPRME_RESETSEL1 && !useFunc && !maint_q |-> busBOeN == 8'hFF)
    else $error("answer during selective reset");
  ts_mm2_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && tsReq && !facReq) && !useFunc && !maint_q
    |-> busBOut[6] == $past(caps.hasMm2 & masterHasMm2))
    else $error("mm bit wrong");
  vote_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (maintTri == 3'h7)[*4] |=> maint_q)
    else $error("vote failed to enter maint");
  slv_int_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && slvIntReq && !facReq) && !useFunc && !maint_q
    |-> busBOut == $past(siOctet))
    else $error("interrupts octet wrong");

  poll_data_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(pollOn) && !maint_q && !useFunc |-> busBOut == ownBit)
    else $error("poll data not own bit");

  quiet_outside_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !(busState inside {SPRME_REQUEST, SPRME_REQUACK}) |=> outOe_q == 8'h00)
    else $error("answer outside request states");

  fac_bit0_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && facReq) |-> outOe_q[0] == 1'b0)
    else $error("facility answer drove bit 0");

  fac_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ackOn && facReq && busAIn[3] |=> outData_q == {$past(facilityInt[15:9]), 1'b0})
    else $error("upper facility range wrong");

  fac_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ackOn && facReq && !busAIn[3] |=> outData_q == {$past(facilityInt[7:1]), 1'b0})
    else $error("lower facility range wrong");

  fac_oe_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && facReq) |-> outOe_q == outData_q)
    else $error("facility answer drove clear bit");

  fac_none_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ackOn && facReq && facilityInt == 15'h0 |=> outOe_q == 8'h00)
    else $error("facility answer without interrupt");

  fac_parity_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && facReq) && !maint_q && !useFunc |-> parityOeN)
    else $error("parity driven on facility octet");

  other_slave_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busState == SPRME_REQUACK && reqForm && !addrHit |=> outOe_q == 8'h00)
    else $error("unaddressed slave answered");

  ts_width_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && tsReq) |-> outData_q[5:4] == $past({curDouble_q, curStream_q}))
    else $error("current setting bits wrong");

  ts_caps_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && tsReq)
    |-> outData_q[3:0] == $past({caps.canStream, caps.canInterlock,
                                 caps.canDouble, caps.canSingle}))
    else $error("capability bits wrong");

  ts_mm1_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ackOn && tsReq && !masterHasMm2 |=> !outData_q[6])
    else $error("mm2 reported to mm1 master");

  si_status_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && slvIntReq)
    |-> outData_q[6:5] == $past({slaveStatus.busy, slaveStatus.ready}))
    else $error("busy or ready bit wrong");

  si_prio_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && slvIntReq)
    |-> outData_q[4:3] == $past({slaveStatus.prioHold, slaveStatus.prioSel}))
    else $error("priority bits wrong");

  si_class_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && slvIntReq) |-> outData_q[2:0] == $past(slaveStatus.classPend))
    else $error("class bits wrong");

  full_drive_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(ackOn && (slvIntReq || tsReq)) && !maint_q && !useFunc
    |-> busBOeN == 8'h00 && !parityOeN)
    else $error("full octet not driven");

  mode_double_a: assert property (@(posedge core_clk) disable iff (!nrst)
    setModeStb && setDouble && caps.canDouble |=> curDouble_q)
    else $error("double width not taken");

  mode_single_a: assert property (@(posedge core_clk) disable iff (!nrst)
    setModeStb && !setDouble && caps.canSingle |=> !curDouble_q)
    else $error("single width not taken");

  mode_stream_a: assert property (@(posedge core_clk) disable iff (!nrst)
    setModeStb && setStream && caps.canStream |=> curStream_q)
    else $error("streaming not taken");

  mode_ilock_a: assert property (@(posedge core_clk) disable iff (!nrst)
    setModeStb && !setStream && caps.canInterlock |=> !curStream_q)
    else $error("interlocked not taken");

  mode_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !setModeStb |=> $stable(curDouble_q) && $stable(curStream_q))
    else $error("mode changed without strobe");

  mm2_only_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !masterHasMm2 |-> !mm2Active)
    else $error("mm2 active with mm1 master");

  divert_on_a: assert property (@(posedge core_clk) disable iff (!nrst)
    maint_q && !maintDriveRel |-> divertToMaint)
    else $error("drivers not diverted");

  divert_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !maint_q |-> !divertToMaint)
    else $error("diverted outside maint");

  vote_two_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (maintTri == 3'b101)[*4] |=> maint_q)
    else $error("open wire broke vote");

  vote_one_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (maintTri == 3'b001)[*4] ##0 busState != SPRME_MAINT |=> !maint_q)
    else $error("single line entered maint");

  vote_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (maintTri == 3'b000)[*4] ##0 busState != SPRME_MAINT |=> !maint_q)
    else $error("maint without voted level");

  maint_state_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busState == SPRME_MAINT && maintStable |=> maint_q)
    else $error("maint state not taken");

  rs_once_a: assert property (@(posedge core_clk) disable iff (!nrst)
    selResetStb |=> !selResetStb)
    else $error("reset strobe longer than one cycle");

  rs_state_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busState != SPRME_RESETSEL1 |-> !selResetStb)
    else $error("reset strobe outside first select");

  rs_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    resetOctet_q[6:4] != SLAVE_ADDR |-> !selResetStb)
    else $error("reset strobe for other slave");

  rs_kind_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busState != SPRME_REQUEST |=> $stable(selResetKind))
    else $error("reset kind changed outside request");

  rs_sel2_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(busState) == SPRME_RESETSEL2 && !useFunc && !maint_q
    |-> busBOeN == 8'hFF && parityOeN)
    else $error("answer during second reset state");

  dominant_pass_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !maint_q |-> dominantGrant == funcDominantReq)
    else $error("dominant request lost");
endmodule : sprme_slave
`default_nettype wire

/* File: tb/sprme_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sprme_master_model
  import sprme_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [1:0] seqKind,
  input  wire logic [7:0] octet,
  input  wire logic [2:0] waitCyc,
  input  wire logic [7:0] busBOut,
  input  wire logic [7:0] busBOeN,
  input  wire logic       parityOeN,
  output var sprme_bus_state_t busState,
  output logic [7:0]      busAIn,
  output logic [16:0]     reqSmp,
  output logic [16:0]     ackSmp,
  output logic            done
);
  logic [16:0] junk;
  // hold a state for waitCyc + 1 cycles, then sample bus b
  task automatic hold(input sprme_bus_state_t st, output logic [16:0] smp);
    busState = st;
    repeat (waitCyc + 1) @(posedge core_clk);
    @(negedge core_clk);
    smp = {parityOeN, busBOeN, busBOut & ~busBOeN};  // parity output enable sampled as bit 16
  endtask : hold
  initial begin
    busState = SPRME_IDLE;
    busAIn   = 8'h00;
    done     = 1'b0;
    forever begin
      @(posedge core_clk iff go);
      @(negedge core_clk);
      done   = 1'b0;
      busAIn = octet;
      hold(SPRME_REQUEST, reqSmp);
      if (seqKind == 2'h1) hold(SPRME_REQUACK, ackSmp);
      if (seqKind == 2'h3) hold(SPRME_MAINT, ackSmp);
      if (seqKind == 2'h2) begin
        hold(SPRME_RESETSEL1, ackSmp);  // answers here are sampled into ackSmp
        hold(SPRME_RESETSEL2, junk);
      end
      busState = SPRME_IDLE;
      busAIn   = ~octet;
      done     = 1'b1;
    end
  end
endmodule : sprme_master_model
`default_nettype wire

/* File: tb/tb_sprme_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sprme_slave
  import sprme_pkg::*;
;
  logic core_clk, nrst, go, powerOn, setModeStb, setDouble, setStream, masterHasMm2;
  logic funcDominantReq, parityOeN, divertToMaint, mm2Active, dominantGrant;
  logic selResetStb, curDouble, curStream, done;
  logic [1:0] seqKind;
  logic [2:0] waitCyc, maintTri;
  logic [3:0] selResetKind;
  logic [7:0] octet, busAIn, busBOut, busBOeN;
  logic [15:1] facilityInt;
  logic [16:0] reqSmp, ackSmp;
  sprme_status_t slaveStatus;
  sprme_caps_t caps;
  sprme_bus_state_t busState;
  int bad_count, n_checks, stbCnt;
  localparam logic [16:0] REL = {1'b1, 8'hFF, 8'h00};
  localparam logic [16:0] HIT = {1'b1, 8'hDF, 8'h20};
  sprme_slave #(.SLAVE_ADDR(3'h5)) i_sprme_slave (.core_clk, .nrst, .busState, .busAIn,
    .slaveStatus, .powerOn, .facilityInt, .caps, .setModeStb, .setDouble, .setStream,
    .masterHasMm2, .maintTri, .funcDriveEn(1'b0), .funcBusBOut(8'h00), .funcDominantReq,
    .maintDriveRel(1'b0), .busBOut, .busBOeN, .parityOeN, .divertToMaint, .mm2Active,
    .dominantGrant, .selResetStb, .selResetKind, .curDouble, .curStream);
  sprme_master_model i_sprme_master_model (.core_clk, .go, .seqKind, .octet, .waitCyc,
    .busBOut, .busBOeN, .parityOeN, .busState, .busAIn, .reqSmp, .ackSmp, .done);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (selResetStb === 1'b1) stbCnt <= stbCnt + 1;
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic run(input logic [1:0] k, input logic [7:0] o, input logic [2:0] w);
    @(negedge core_clk);
    seqKind = k;
    octet = o;
    waitCyc = w;
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    repeat (60) begin
      @(posedge core_clk);
      if (done === 1'b1) break;
    end
  endtask : run
  task automatic t_poll;
    logic [7:0] oct [7] = '{8'h40, 8'h20, 8'h60, 8'h08, 8'h04, 8'h02, 8'h01};
    logic hit [7] = '{0, 1, 1, 1, 0, 1, 0};
    chk("idle", REL, {parityOeN, busBOeN, 8'h00});
    chk("modes", 17'h0, {15'h0, curDouble, curStream});
    slaveStatus = 8'h22;
    foreach (oct[i]) begin
      run(2'h0, oct[i], 3'(i % 3 + 1));
      chk("poll", hit[i] ? HIT : REL, reqSmp);
    end
  endtask : t_poll
  task automatic t_octets;
    @(negedge core_clk);
    slaveStatus = 8'hD5;
    run(2'h1, 8'hD8, 3'h2);
    chk("slvint", {1'b0, 8'h00, 8'hD5}, ackSmp);
    run(2'h1, 8'hC8, 3'h1);
    chk("slvint other", REL, ackSmp);
    run(2'h1, 8'hD0, 3'h1);
    chk("settings mm1", {1'b0, 8'h00, 8'h0F}, ackSmp);
    @(negedge core_clk);
    masterHasMm2 = 1'b1;
    setDouble = 1'b1;
    setStream = 1'b1;
    setModeStb = 1'b1;
    @(negedge core_clk);
    setModeStb = 1'b0;
    run(2'h1, 8'hD0, 3'h3);
    chk("settings", {1'b0, 8'h00, 8'h7F}, ackSmp);
    run(2'h1, 8'hD9, 3'h2);
    chk("facility hi", {1'b1, 8'h7D, 8'h82}, ackSmp);
    run(2'h1, 8'hD1, 3'h1);
    chk("facility lo", {1'b1, 8'hF7, 8'h08}, ackSmp);
  endtask : t_octets
  task automatic t_selreset;
    stbCnt = 0;
    run(2'h2, 8'h5A, 3'h1);
    chk("rst stb", 17'h1, 17'(stbCnt));
    chk("rst kind", 17'hA, {13'h0, selResetKind});
    chk("rst busb", REL, ackSmp);
    stbCnt = 0;
    run(2'h2, 8'h4A, 3'h2);
    chk("rst other", 17'h0, 17'(stbCnt));
  endtask : t_selreset
  task automatic t_maint;
    @(negedge core_clk);
    slaveStatus = 8'h40;
    maintTri = 3'b001;
    repeat (8) @(negedge core_clk);
    chk("one line", {1'b0, 8'hFF, 8'h01}, {divertToMaint, 8'hFF, 7'h0, dominantGrant});
    maintTri = 3'b101;
    repeat (8) @(negedge core_clk);
    chk("maint", REL, {divertToMaint, busBOeN, 7'h0, dominantGrant});
    chk("mm2", 17'h1, {16'h0, mm2Active});
    maintTri = 3'b111;
    repeat (8) @(negedge core_clk);
    chk("maint all", REL, {divertToMaint, busBOeN, 7'h0, dominantGrant});
    run(2'h0, 8'h40, 3'h1);
    chk("maint poll", REL, reqSmp);
    maintTri = 3'b000;
    repeat (8) @(negedge core_clk);
    run(2'h0, 8'h40, 3'h1);
    chk("back", HIT, reqSmp);
    run(2'h3, 8'h40, 3'h2);
    chk("maint state", REL, ackSmp);
  endtask : t_maint
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    {nrst, go, setModeStb, setDouble, setStream, masterHasMm2} = 6'h00;
    {funcDominantReq, powerOn, maintTri, slaveStatus} = {2'b11, 3'h0, 8'h00};
    {seqKind, waitCyc, octet, facilityInt, caps} = {2'h0, 3'h1, 8'h00, 15'h4104, 5'h1F};
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    t_poll;
    t_octets;
    t_selreset;
    t_maint;
    finish_test;
  end
  // the whole run takes under 200 cycles
  initial begin
    #20000;
    bad_count++;
    finish_test;
  end
endmodule : tb_sprme_slave
`default_nettype wire
